// ---- hdl/adc_converter.sv ----
// Converter end: calibration, conversion sequencing and result latching.
// Overview of operation
// - Power-up calibration 3840 converter clocks, flagged
// - Eight-bit calibration array trims offset, linearity
// - Post-calibration after every conversion
// - Controller pulses start one cycle
// - Sampling and busy rise together
// - Sampling drops after hold, busy stays
// - Completion: busy low, valid high, result
// - Valid held until next start
// - Result latched until next valid rise
// - Controller captures result while valid
// - Five-bit binary channel select, 32 inputs
// - Channel 0 supply, channel 31 temperature
// - Channels 1-30 grouped three per quad
// - Controller strobes diode before temperature
// - Powerdown stops comparators only
// - Inputs sampled on rising system clock
// - Eight/ten-bit results zero-fill low bits
// - Converter clock is 4*(1+divider) system clocks
`timescale 1ns/1ps
module adc_converter #(
  parameter int unsigned PWRUP_CAL = adc_ctrl_pkg::PWRUP_CAL_CYCLES
) (
  // Clock and reset.
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  // Analog side: comparator decision and channel routing to the front end.
  input  wire logic                           comp_out,
  output logic [4:0]                          mux_channel,
  output adc_ctrl_pkg::input_kind_t           mux_kind,
  output logic [3:0]                          mux_quad,
  output logic [adc_ctrl_pkg::CAL_W-1:0]      cal_trim,
  output logic                                comp_enable,
  output logic                                temp_diode_strobe,
  // Control link.
  adc_ctrl_if.converter                       ctl
);
  typedef enum logic [2:0] {ST_PWRCAL, ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_POSTCAL} state_t;
  localparam int unsigned CAL_CW = $clog2(PWRUP_CAL + 1);

  state_t                          state_q;
  logic [9:0]                      div_cnt_q;
  logic                            tick;
  logic [CAL_CW-1:0]               cnt_q;
  logic [3:0]                      bit_q;
  logic [adc_ctrl_pkg::RESULT_W-1:0] sar_q;
  logic [1:0]                      res_q;
  logic [4:0]                      chan_q;
  logic [3:0]                      post_idx_q;
  logic                            start_ok;
  logic [3:0]                      lsb_bit;
  logic                            comp_s1_q;
  logic                            comp_s2_q;

  // The converter clock is an enable every 4*(1+divider) system clocks.
  // The compare is >= so that a lowered divider takes effect at once instead of wrapping the counter.
  assign tick = (div_cnt_q >= 10'((adc_ctrl_pkg::DIV_BASE * (ctl.clock_divider_setting + 1)) - 1));
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      div_cnt_q <= 10'h000;
    else if (tick)
      div_cnt_q <= 10'h000;
    else
      div_cnt_q <= div_cnt_q + 10'h001;
  end

  // Starts sampled only at rising edges, and only from idle.
  assign start_ok = ctl.conv_start_pulse && (state_q == ST_IDLE);
  assign lsb_bit  = (res_q == adc_ctrl_pkg::RES_8) ? 4'h4 : (res_q == adc_ctrl_pkg::RES_10) ? 4'h2 : 4'h0;

  // The comparator decision is not timed to the system clock, so it passes two flip-flops first.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_out;
      comp_s2_q <= comp_s1_q;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_PWRCAL;
      cnt_q   <= '0;
      bit_q   <= 4'h0;
      sar_q   <= 12'h000;
    end else begin
      unique case (state_q)
        ST_PWRCAL: if (tick) begin
          if (cnt_q == CAL_CW'(PWRUP_CAL - 1)) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_IDLE: if (start_ok) begin
          state_q <= ST_SAMPLE;
          cnt_q   <= '0;
        end
        ST_SAMPLE: if (tick) begin
          if (cnt_q == CAL_CW'(adc_ctrl_pkg::SAMPLE_CYCLES - 1)) begin
            state_q <= ST_CONVERT;
            bit_q   <= 4'hB;
            sar_q   <= 12'h800;
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_CONVERT: if (tick) begin
          // Successive approximation: keep or drop the trial bit, then try the next one.
          if (!comp_s2_q)
            sar_q[bit_q] <= 1'b0;
          if (bit_q == lsb_bit) begin
            state_q <= ST_POSTCAL;
            cnt_q   <= '0;
          end else begin
            bit_q            <= bit_q - 4'h1;
            sar_q[bit_q - 1] <= 1'b1;
          end
        end
        ST_POSTCAL: if (tick) begin
          if (cnt_q == CAL_CW'(adc_ctrl_pkg::POST_CAL_CYCLES - 1))
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q + 1'b1;
        end
      endcase
    end
  end

  // Captured settings hold steady through a conversion even if the controller moves on.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      res_q  <= adc_ctrl_pkg::RES_12;
      chan_q <= 5'h00;
    end else if (start_ok) begin
      res_q  <= ctl.res_mode;
      chan_q <= ctl.channel_select;
    end
  end

  // Channel decode: fixed supply and diode ends, quads in groups of three between.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mux_channel <= 5'h00;
      mux_kind    <= adc_ctrl_pkg::INPUT_FIXED;
      mux_quad    <= 4'h0;
    end else begin
      mux_channel <= chan_q;
      if (chan_q == adc_ctrl_pkg::CHAN_SUPPLY || chan_q == adc_ctrl_pkg::CHAN_TEMP) begin
        mux_kind <= adc_ctrl_pkg::INPUT_FIXED;
        mux_quad <= 4'h0;
      end else begin
        mux_quad <= 4'((chan_q - 5'h01) / 5'h03);
        unique case (5'((chan_q - 5'h01) % 5'h03))
          5'h00:   mux_kind <= adc_ctrl_pkg::INPUT_VOLT;
          5'h01:   mux_kind <= adc_ctrl_pkg::INPUT_CURR;
          default: mux_kind <= adc_ctrl_pkg::INPUT_TEMP;
        endcase
      end
    end
  end

  // Calibration trim: a ramp during power-up, then one array element per conversion.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cal_trim   <= 8'h00;
      post_idx_q <= 4'h0;
    end else if (state_q == ST_PWRCAL && tick) begin
      cal_trim <= 8'(cnt_q >> 4);
    end else if (state_q == ST_POSTCAL && tick && cnt_q == '0) begin
      post_idx_q <= (post_idx_q == 4'hC) ? 4'h0 : post_idx_q + 4'h1;
      cal_trim   <= {4'h0, post_idx_q};
    end
  end

  // Status, powerdown and strobe outputs, all registered.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl.calibrating   <= 1'b1;
      ctl.sampling      <= 1'b0;
      ctl.busy          <= 1'b0;
      comp_enable       <= 1'b0;
      temp_diode_strobe <= 1'b0;
    end else begin
      ctl.calibrating   <= (state_q == ST_PWRCAL) && !(tick && cnt_q == CAL_CW'(PWRUP_CAL - 1));
      ctl.sampling      <= start_ok || (ctl.sampling && state_q == ST_SAMPLE &&
                           !(tick && cnt_q == CAL_CW'(adc_ctrl_pkg::SAMPLE_CYCLES - 1)));
      ctl.busy          <= start_ok || (ctl.busy && !(state_q == ST_CONVERT && tick && bit_q == lsb_bit));
      comp_enable       <= !ctl.comparator_powerdown;
      temp_diode_strobe <= ctl.internal_temp_strobe;
    end
  end

  // Valid clears on the start edge; result only moves when valid rises again.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl.result_valid <= 1'b0;
      ctl.result       <= 12'h000;
    end else if (state_q == ST_CONVERT && tick && bit_q == lsb_bit) begin
      ctl.result_valid <= 1'b1;
      ctl.result       <= (comp_s2_q ? sar_q : (sar_q & ~(12'h001 << bit_q))) &
                          ~((12'h001 << lsb_bit) - 12'h001);
    end else if (start_ok) begin
      ctl.result_valid <= 1'b0;
    end
  end
endmodule // adc_converter

// ---- hdl/adc_ctrl_pkg.sv ----
// Shared constants and types for the converter control link.
package adc_ctrl_pkg;
  localparam int unsigned RESULT_W         = 12;
  localparam int unsigned CHAN_W           = 5;
  localparam int unsigned DIV_W            = 8;
  localparam int unsigned CAL_W            = 8;
  localparam int unsigned PWRUP_CAL_CYCLES = 3840;
  localparam int unsigned POST_CAL_CYCLES  = 2;
  localparam int unsigned SAMPLE_CYCLES    = 2;
  localparam int unsigned DIV_BASE         = 4;
  localparam logic [4:0]  CHAN_SUPPLY      = 5'h00;
  localparam logic [4:0]  CHAN_TEMP        = 5'h1F;
  localparam logic [7:0]  DIV_RESET        = 8'h00;
  typedef enum logic [1:0] {RES_10 = 2'h0, RES_12 = 2'h1, RES_8 = 2'h2} res_mode_t;
  typedef enum logic [1:0] {INPUT_VOLT, INPUT_CURR, INPUT_TEMP, INPUT_FIXED} input_kind_t;
endpackage

// ---- hdl/adc_ctrl_if.sv ----
// Interface joining the converter end and the controlling fabric logic.
`timescale 1ns/1ps
interface adc_ctrl_if;
  logic       conv_start_pulse;
  logic [4:0] channel_select;
  logic [7:0] clock_divider_setting;
  logic [1:0] res_mode;
  logic       internal_temp_strobe;
  logic       comparator_powerdown;
  logic       calibrating;
  logic       sampling;
  logic       busy;
  logic       result_valid;
  logic [11:0] result;
  modport converter (input conv_start_pulse, channel_select, clock_divider_setting, res_mode,
                     internal_temp_strobe, comparator_powerdown,
                     output calibrating, sampling, busy, result_valid, result);
  modport controller (output conv_start_pulse, channel_select, clock_divider_setting, res_mode,
                      internal_temp_strobe, comparator_powerdown,
                      input calibrating, sampling, busy, result_valid, result);
endinterface

// ---- hdl/adc_controller.sv ----
// Controlling fabric end: issues start pulses and captures results.
`timescale 1ns/1ps
module adc_controller #(
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // User request side.
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [4:0]  req_channel,
  input  wire logic [7:0]  divider,
  input  wire logic [1:0]  resolution,
  input  wire logic        powerdown,
  // User result side.
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [11:0]      out_data,
  output logic [4:0]       out_channel,
  // Converter link.
  adc_ctrl_if.controller   ctl
);
  typedef enum logic [1:0] {C_IDLE, C_STROBE, C_WAIT, C_GUARD} cstate_t;
  cstate_t     state_q;
  logic [4:0]  chan_q;
  logic [11:0] guard_q;
  logic [11:0] guard_lim;
  logic        take;
  logic [16:0] buf_q [DEPTH];
  logic        wr_ptr_q;
  logic        rd_ptr_q;
  logic [1:0]  count_q;
  logic        valid_d1_q;
  logic        push;
  logic        pop;
  logic        can_start;

  assign push      = ctl.result_valid && !valid_d1_q;
  assign pop       = out_valid && out_ready;
  // A request is only taken when the buffer can hold its result, so a stall loses nothing.
  assign can_start = (state_q == C_IDLE) && !ctl.calibrating && !ctl.busy && (count_q == 2'h0);
  assign take      = can_start && req_valid && req_ready;
  // Busy falls before post-calibration ends, so a start in that gap would be ignored; the guard waits it out.
  assign guard_lim = 12'(adc_ctrl_pkg::POST_CAL_CYCLES * adc_ctrl_pkg::DIV_BASE * (ctl.clock_divider_setting + 1));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q              <= C_IDLE;
      chan_q               <= 5'h00;
      guard_q              <= 12'h000;
      ctl.conv_start_pulse <= 1'b0;
      ctl.internal_temp_strobe <= 1'b0;
      req_ready            <= 1'b0;
    end else begin
      ctl.conv_start_pulse     <= 1'b0;
      ctl.internal_temp_strobe <= 1'b0;
      req_ready                <= can_start && !take;
      unique case (state_q)
        C_IDLE: if (take) begin
          chan_q <= req_channel;
          if (req_channel == adc_ctrl_pkg::CHAN_TEMP) begin
            ctl.internal_temp_strobe <= 1'b1;
            state_q <= C_STROBE;
          end else begin
            ctl.conv_start_pulse <= 1'b1;
            state_q <= C_WAIT;
          end
        end
        C_STROBE: begin
          ctl.conv_start_pulse <= 1'b1;
          state_q <= C_WAIT;
        end
        C_WAIT: if (push) begin
          state_q <= C_GUARD;
          guard_q <= 12'h000;
        end
        C_GUARD: if (guard_q == guard_lim)
          state_q <= C_IDLE;
        else
          guard_q <= guard_q + 12'h001;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl.channel_select        <= 5'h00;
      ctl.clock_divider_setting <= adc_ctrl_pkg::DIV_RESET;
      ctl.res_mode              <= adc_ctrl_pkg::RES_12;
      ctl.comparator_powerdown  <= 1'b0;
    end else begin
      if (take)
        ctl.channel_select <= req_channel;
      // The divider only moves between conversions, so the guard and the converter count the same ticks.
      if (state_q == C_IDLE)
        ctl.clock_divider_setting <= divider;
      ctl.res_mode              <= resolution;
      ctl.comparator_powerdown  <= powerdown;
    end
  end

  // Two-entry result buffer.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      valid_d1_q <= 1'b0;
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      count_q    <= 2'h0;
      for (int i = 0; i < DEPTH; i++)
        buf_q[i] <= 17'h00000;
    end else begin
      valid_d1_q <= ctl.result_valid;
      if (push && count_q != 2'(DEPTH)) begin
        buf_q[wr_ptr_q] <= {chan_q, ctl.result};
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + 2'(push && count_q != 2'(DEPTH)) - 2'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid   <= 1'b0;
      out_data    <= 12'h000;
      out_channel <= 5'h00;
    end else begin
      out_valid   <= (count_q - 2'(pop)) != 2'h0 || push;
      out_data    <= 12'h000;
      out_channel <= 5'h00;
      if (count_q - 2'(pop) != 2'h0)
        {out_channel, out_data} <= buf_q[pop ? ~rd_ptr_q : rd_ptr_q];
      else if (push)
        {out_channel, out_data} <= {chan_q, ctl.result};
    end
  end
endmodule // adc_controller

// ---- verification/adc_link_props.sv ----
// Checker for the converter control link.
`timescale 1ns/1ps
module adc_link_props #(
  parameter int unsigned PWRUP_CAL = 3840
) (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Link signals.
  input wire logic        conv_start_pulse,
  input wire logic [4:0]  channel_select,
  input wire logic [7:0]  clock_divider_setting,
  input wire logic [1:0]  res_mode,
  input wire logic        internal_temp_strobe,
  input wire logic        calibrating,
  input wire logic        sampling,
  input wire logic        busy,
  input wire logic        result_valid,
  input wire logic [11:0] result
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [23:0] cal_cnt_q;
  logic [23:0] cal_lim;
  // Limit grows with the divider, so the window scales with the converter tick.
  assign cal_lim = 24'(PWRUP_CAL) * 24'h4 * (24'(clock_divider_setting) + 24'h1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) cal_cnt_q <= '0;
    else if (calibrating) cal_cnt_q <= cal_cnt_q + 24'h1;
  end
  property p_cal_len; $fell(calibrating) |-> cal_cnt_q + 24'h4 >= cal_lim && cal_cnt_q <= cal_lim + 24'h4; endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  property p_cal_idle; calibrating |-> !busy && !sampling; endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("busy during calibration");
  property p_pulse; conv_start_pulse |=> !conv_start_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_rise; $rose(busy) |-> $rose(sampling) && $past(conv_start_pulse) && !result_valid; endproperty
  a_rise: assert property (p_rise) else $error("busy rose without sampling");
  property p_sample; $rose(sampling) |-> (sampling && busy) [*4]; endproperty
  a_sample: assert property (p_sample) else $error("sample phase too short");
  property p_done; $rose(result_valid) |-> $fell(busy); endproperty
  a_done: assert property (p_done) else $error("valid without busy fall");
  property p_bound; clock_divider_setting < 8'h0C && $rose(busy) |-> ##[8:1000] $fell(busy); endproperty
  a_bound: assert property (p_bound) else $error("conversion did not finish");
  property p_valid_hold; $fell(result_valid) |-> $rose(busy); endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped without start");
  property p_latch; !$rose(result_valid) |-> $stable(result); endproperty
  a_latch: assert property (p_latch) else $error("result changed while latched");
  property p_low8; $rose(result_valid) && res_mode == 2'h2 |-> result[3:0] == 4'h0; endproperty
  a_low8: assert property (p_low8) else $error("eight-bit low nibble not zero");
  property p_strobe; conv_start_pulse && channel_select == 5'h1F |-> $past(internal_temp_strobe); endproperty
  a_strobe: assert property (p_strobe) else $error("temperature start without strobe");
  c_conv: cover property ($rose(result_valid));
  c_temp: cover property (conv_start_pulse && channel_select == 5'h1F);
  c_cal: cover property ($fell(calibrating));
endmodule // adc_link_props

// ---- verification/testbench.sv ----
// Self-checking bench for the converter and controller ends.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam int unsigned PW = 4;
  logic sys_clk = 1'b0, resetn = 1'b0, comp_out = 1'b0, req_valid = 1'b0, out_ready = 1'b1, powerdown = 1'b0;
  logic [4:0] req_channel = 5'h00;
  logic [7:0] divider = 8'h00;
  logic [1:0] resolution = 2'h1;
  logic req_ready, out_valid, comp_enable, temp_diode_strobe;
  logic [11:0] out_data, got;
  logic [4:0] out_channel, mux_channel;
  logic [3:0] mux_quad;
  logic [7:0] cal_trim;
  adc_ctrl_pkg::input_kind_t mux_kind;
  int errors = 0, n_compared = 0, busy_n, strobe_n;
  always #10 sys_clk = ~sys_clk;
  adc_ctrl_if ifc ();
  adc_converter #(.PWRUP_CAL(PW)) adc_converter_inst (.sys_clk(sys_clk), .resetn(resetn), .comp_out(comp_out),
    .mux_channel(mux_channel), .mux_kind(mux_kind), .mux_quad(mux_quad), .cal_trim(cal_trim),
    .comp_enable(comp_enable), .temp_diode_strobe(temp_diode_strobe), .ctl(ifc.converter));
  adc_controller adc_controller_inst (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_channel(req_channel), .divider(divider), .resolution(resolution),
    .powerdown(powerdown), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_channel(out_channel), .ctl(ifc.controller));
  adc_link_props #(.PWRUP_CAL(PW)) adc_link_props_inst (.sys_clk(sys_clk), .resetn(resetn),
    .conv_start_pulse(ifc.conv_start_pulse), .channel_select(ifc.channel_select),
    .clock_divider_setting(ifc.clock_divider_setting), .res_mode(ifc.res_mode),
    .internal_temp_strobe(ifc.internal_temp_strobe), .calibrating(ifc.calibrating), .sampling(ifc.sampling),
    .busy(ifc.busy), .result_valid(ifc.result_valid), .result(ifc.result));
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset and wait out power-up calibration; used again mid-run.
  task automatic t_cal();
    int n;
    n = 0;
    @(posedge sys_clk) resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    `CHK(ifc.calibrating, 1'b1)
    while (ifc.calibrating === 1'b1 && n < 200) begin @(posedge sys_clk); #1; n++; end
    `CHK(n >= PW * 4 - 4 && n <= PW * 4 + 4, 1'b1)
  endtask
  // Hand one request over and wait for its result while counting busy cycles.
  task automatic convert(input logic [4:0] ch, input logic [1:0] res, input logic [7:0] div, input logic cmp);
    int n;
    n = 0; busy_n = 0; strobe_n = 0;
    @(posedge sys_clk);
    req_channel <= ch; resolution <= res; divider <= div; comp_out <= cmp; req_valid <= 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 9000) begin @(posedge sys_clk); #1; n++; end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    while (out_valid !== 1'b1 && n < 9000) begin
      busy_n += (ifc.busy === 1'b1);
      strobe_n += (ifc.internal_temp_strobe === 1'b1) + (temp_diode_strobe === 1'b1);
      @(posedge sys_clk); #1; n++;
    end
    `CHK(n < 9000, 1'b1)
    got = out_data;
    `CHK(out_channel, ch)
    `CHK(strobe_n, (ch == adc_ctrl_pkg::CHAN_TEMP) ? 2 : 0)
  endtask
  // Every resolution, both comparator levels, three divider settings.
  task automatic t_modes();
    int bits, p;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      r = (i / 2 == 0) ? adc_ctrl_pkg::RES_12 : (i / 2 == 1) ? adc_ctrl_pkg::RES_10 : adc_ctrl_pkg::RES_8;
      bits = 12 - 2 * (i / 2);
      p = 4 * (1 + i / 2);
      convert(5'h05, r, 8'(i / 2), 1'(i % 2));
      `CHK(got, (i % 2) ? 12'(12'hFFF << (12 - bits)) : 12'h000)
      `CHK(busy_n >= (1 + bits) * p && busy_n <= (3 + bits) * p, 1'b1)
    end
  endtask
  task automatic t_chan();
    logic [4:0] list [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E};
    foreach (list[i]) begin
      convert(list[i], adc_ctrl_pkg::RES_12, 8'h00, 1'b1);
      `CHK(mux_channel, list[i])
      if (list[i] == 5'h00) `CHK(mux_kind, adc_ctrl_pkg::INPUT_FIXED)
      else begin
        `CHK(mux_kind, adc_ctrl_pkg::input_kind_t'((list[i] - 5'h01) % 5'h03))
        `CHK(mux_quad, 4'((list[i] - 5'h01) / 5'h03))
      end
    end
    convert(adc_ctrl_pkg::CHAN_TEMP, adc_ctrl_pkg::RES_12, 8'h00, 1'b0);
    `CHK(strobe_n > 0, 1'b1)
    `CHK(mux_channel, 5'h1F)
  endtask
  // The receiver stalls: the word must stand and no new request is taken.
  task automatic t_stall();
    // Thirteen conversions so far, so the last post-calibration trimmed element twelve.
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK(cal_trim, 8'h0C)
    @(posedge sys_clk) out_ready <= 1'b0;
    convert(5'h07, adc_ctrl_pkg::RES_12, 8'h00, 1'b1);
    repeat (20) begin
      @(posedge sys_clk); #1;
      `CHK({out_valid, req_ready, out_data}, {2'b10, got})
    end
    @(posedge sys_clk) out_ready <= 1'b1;
    @(posedge sys_clk); #1;
    `CHK(out_valid, 1'b0)
  endtask
  task automatic t_pd();
    @(posedge sys_clk) powerdown <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK({comp_enable, ifc.calibrating}, 2'b00)
    @(posedge sys_clk) powerdown <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(comp_enable, 1'b1)
  endtask
  initial begin
    t_cal();
    t_modes();
    t_chan();
    t_stall();
    t_pd();
    t_cal();
    convert(5'h02, adc_ctrl_pkg::RES_8, 8'h00, 1'b1);
    `CHK(got, 12'hFF0)
    summarize();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #400us;
    errors++;
    summarize();
  end
endmodule // testbench
